// file: dv/dram_on_die_termination_ctrl_tb_top.sv
// Purpose: self-checking bench for the termination controller
// Assumes: host model drives the link side on mem_clk
// Notes:   random configs plus corner bursts, fixed seed
`timescale 1ns/10ps
`default_nettype none
module dram_on_die_termination_ctrl_tb_top;
    localparam logic [3:0] DIV_TAB [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8, 4'h0, 4'h0};
    localparam logic [4:0] RSV_TAB [4] = '{5'h18, 5'h1C, 5'h07, 5'h16};
    logic               clock, rst, mem_clk, sref_active, dll_off_ppd, dll_relock;
    logic [2:0]         nom_code;
    logic [1:0]         wr_code;
    logic [3:0]         cwl, al, nom_seen;
    logic               cfg_busy, cfg_illegal, core_term_on, core_high_err, core_read_err;
    logic               odt_pin, wr_cmd, wr_chop, rd_cmd, saw_on, saw_wr, saw_core;
    dtc_pkg::dtc_term_s term;
    int                 fails, comparisons, seed;
    logic [31:0]        r;

    dtc_ctrl u_dut (
        .clock(clock), .rst(rst), .nom_code(nom_code), .wr_code(wr_code), .cwl(cwl), .al(al),
        .sref_active(sref_active), .dll_off_ppd(dll_off_ppd), .dll_relock(dll_relock),
        .cfg_busy(cfg_busy), .cfg_illegal(cfg_illegal), .core_term_on(core_term_on),
        .core_high_err(core_high_err), .core_read_err(core_read_err), .mem_clk(mem_clk),
        .odt_pin(odt_pin), .wr_cmd(wr_cmd), .wr_chop(wr_chop), .rd_cmd(rd_cmd), .term(term));
    dtc_host_model u_host (.mem_clk(mem_clk), .odt_pin(odt_pin), .wr_cmd(wr_cmd),
        .wr_chop(wr_chop), .rd_cmd(rd_cmd));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        mem_clk = 1'b0;
        #13;
        forever #40 mem_clk = ~mem_clk;
    end
    always @(posedge mem_clk) begin
        if (term.on === 1'b1 && term.wr_sel === 1'b0) nom_seen = term.div;
        if (term.on === 1'b1) saw_on = 1'b1;
        if (term.wr_sel === 1'b1) saw_wr = 1'b1;
    end
    always @(posedge clock) begin
        if (core_term_on === 1'b1) saw_core = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    function automatic logic exp_wr(input logic wr);
        return wr && !sref_active && !dll_off_ppd && !dll_relock && (wr_code inside {2'h1, 2'h2});
    endfunction
    function automatic logic exp_on(input logic wr);
        return !sref_active && (DIV_TAB[nom_code] != 4'h0 || exp_wr(wr));
    endfunction

    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic do_reset;
        @(posedge clock);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
    endtask
    task automatic set_cfg(input logic [12:0] c, input logic [2:0] m);
        @(posedge clock);
        #1;
        {nom_code, wr_code, cwl, al} = c;
        {sref_active, dll_off_ppd, dll_relock} = m;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 100 && cfg_busy !== 1'b0; i++) @(posedge clock);
        if (cfg_busy !== 1'b0) fails++;
        repeat (36) @(posedge mem_clk);
    endtask
    task automatic run(input int pre, input int hold, input int cmd, input logic chop,
                       input logic brk);
        {saw_on, saw_wr, saw_core, nom_seen} = 7'h00;
        u_host.burst(pre, hold, cmd, chop, brk);
    endtask
    task automatic burst_chk(input int pre, input int hold, input int cmd, input logic chop);
        run(pre, hold, cmd, chop, 1'b0);
        check(4'(saw_on), 4'(exp_on(cmd == 1)));
        check(4'(saw_wr), 4'(exp_wr(cmd == 1)));
        check(4'(saw_core), 4'(!sref_active && (DIV_TAB[nom_code] != 4'h0 ||
                                wr_code inside {2'h1, 2'h2})));
        if (!exp_wr(cmd == 1)) check(nom_seen, sref_active ? 4'h0 : DIV_TAB[nom_code]);
    endtask

    initial begin
        #1000000;
        fails++;
        stop_test();
    end

    initial begin
        seed = 32'h38963292;
        fails = 0;
        comparisons = 0;
        {rst, sref_active, dll_off_ppd, dll_relock} = 4'h8;
        {nom_code, wr_code, cwl, al} = {3'h1, 2'h1, 4'h5, 4'h0};
        {saw_on, saw_wr, saw_core, nom_seen} = 7'h00;
        do_reset();
        set_cfg({3'h1, 2'h1, 4'h5, 4'h0}, 3'h0);
        burst_chk(0, 4, 0, 1'b0);
        burst_chk(1, 7, 1, 1'b0);
        burst_chk(2, 6, 1, 1'b1);
        for (int t = 0; t < 16; t++) begin
            r = $random(seed);
            set_cfg({3'(r[7:0] % 6), 2'(r[9:8] % 3), 4'h5 + 4'(r[11:10]), 4'(r[13:12] % 3)},
                    {1'b0, r[15], r[14] & !r[15]});
            burst_chk(int'(r[20:19]), 4 + int'(r[23:21]), int'(r[24]), r[25]);
        end
        check(4'(core_high_err), 4'h0);
        check(4'(core_read_err), 4'h0);
        for (int i = 0; i < 4; i++) begin
            set_cfg({RSV_TAB[i], 4'h5, 4'h0}, 3'h0);
            check(4'(cfg_illegal), 4'(i < 3));
        end
        set_cfg({3'h2, 2'h0, 4'h6, 4'h1}, 3'h4);
        burst_chk(0, 5, 0, 1'b0);
        set_cfg({3'h2, 2'h0, 4'h6, 4'h1}, 3'h0);
        run(0, 3, 0, 1'b0, 1'b1);
        check(4'(core_high_err), 4'h1);
        do_reset();
        set_cfg({3'h3, 2'h2, 4'h5, 4'h0}, 3'h0);
        run(0, 5, 1, 1'b0, 1'b1);
        check(4'(core_high_err), 4'h1);
        do_reset();
        set_cfg({3'h3, 2'h2, 4'h5, 4'h0}, 3'h0);
        run(1, 5, 2, 1'b0, 1'b1);
        check(4'(core_read_err), 4'h1);
        stop_test();
    end
endmodule
`default_nettype wire

// file: dv/dtc_ctrl_chk.sv
// Purpose: concurrent checks on termination timing and status flags
// Assumes: config and mode inputs held steady while odt is used
// Notes:   on-time, nominal divisor and window checks wait until config has been quiet 31 link clocks
`timescale 1ns/10ps
`default_nettype none
module dtc_ctrl_chk (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic [2:0]         nom_code,
    input wire logic [1:0]         wr_code,
    input wire logic [3:0]         cwl,
    input wire logic [3:0]         al,
    input wire logic               sref_active,
    input wire logic               dll_off_ppd,
    input wire logic               dll_relock,
    input wire logic               cfg_illegal,
    input wire logic               core_high_err,
    input wire logic               core_read_err,
    input wire logic               mem_clk,
    input wire logic               odt_pin,
    input wire logic               wr_cmd,
    input wire logic               wr_chop,
    input wire logic               rd_cmd,
    input wire dtc_pkg::dtc_term_s term
);
    logic [15:0] odt_ff, wr_ff, chp_ff, cfg_ff, cfg_now;
    logic [4:0]  quiet_ff;
    logic [3:0]  ndiv;
    logic        asyn, win, wr_ok, exp_on, rsv;
    int          lat;

    assign cfg_now = {nom_code, wr_code, cwl, al, sref_active, dll_off_ppd, dll_relock};
    assign lat     = int'(cwl) + int'(al) - 2;
    assign asyn    = dll_off_ppd | dll_relock;
    assign wr_ok   = (wr_code == 2'h1) || (wr_code == 2'h2);
    assign rsv     = (nom_code[2:1] == 2'h3) || (wr_code == 2'h3);
    assign exp_on  = !sref_active && odt_ff[asyn ? 2 : lat]
                     && (ndiv != 4'h0 || (!asyn && wr_ok && win));

    always_comb begin
        case (nom_code)
            3'h1: ndiv = 4'h4;
            3'h2: ndiv = 4'h2;
            3'h3: ndiv = 4'h6;
            3'h4: ndiv = 4'hC;
            3'h5: ndiv = 4'h8;
            default: ndiv = 4'h0;
        endcase
    end

    // write window from command history
    always_comb begin
        win = 1'b0;
        for (int k = 0; k < 16; k++) begin
            if (wr_ff[k] && k >= lat && k <= lat + (chp_ff[k] ? 3 : 5)) win = 1'b1;
        end
    end

    always_ff @(posedge mem_clk) begin
        odt_ff <= {odt_ff[14:0], odt_pin};
        wr_ff  <= {wr_ff[14:0], wr_cmd};
        chp_ff <= {chp_ff[14:0], wr_chop};
        cfg_ff <= cfg_now;
        if (rst || cfg_ff != cfg_now) begin
            quiet_ff <= 5'h00;
        end else if (quiet_ff != 5'h1F) begin
            quiet_ff <= quiet_ff + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    AST_ON_TIMING: assert property (@(posedge mem_clk) disable iff (rst)
        quiet_ff == 5'h1F |-> term.on == exp_on)
        else $error("termination state differs from latency model");
    AST_NOM_DIV: assert property (@(posedge mem_clk) disable iff (rst)
        quiet_ff == 5'h1F && term.on && !term.wr_sel |-> term.div == ndiv)
        else $error("nominal divisor wrong");
    AST_STRENGTH: assert property (@(posedge mem_clk) disable iff (rst)
        term.on ? (term.div != 4'h0 && 12'(term.ohm) * 12'(term.div) == 12'h0F0)
                : (term.div == 4'h0 && !term.wr_sel))
        else $error("strength and divisor disagree");
    AST_WR_SEL: assert property (@(posedge mem_clk) disable iff (rst)
        quiet_ff == 5'h1F |-> term.wr_sel == (term.on && !asyn && wr_ok && win))
        else $error("write strength window wrong");
    AST_WR_DIV: assert property (@(posedge mem_clk) disable iff (rst)
        term.wr_sel |-> term.div == ((wr_code == 2'h1) ? 4'h4 : 4'h2))
        else $error("write divisor wrong");
    AST_RSV_FLAG: assert property (@(posedge clock) disable iff (rst)
        cfg_illegal == $past(rsv))
        else $error("reserved code flag wrong");
    AST_READ_ERR: assert property (@(posedge mem_clk) disable iff (rst)
        rd_cmd && odt_pin |-> ##[1:12] core_read_err)
        else $error("odt high in read not flagged");
    AST_HIGH_ERR: assert property (@(posedge mem_clk) disable iff (rst)
        $fell(odt_pin) && !$past(odt_pin, 4) && !sref_active |-> ##[1:12] core_high_err)
        else $error("short odt pulse not flagged");
    AST_ERR_HOLD: assert property (@(posedge clock) disable iff (rst)
        core_read_err |=> core_read_err)
        else $error("read error flag dropped");

    cover property (@(posedge mem_clk) disable iff (rst) $rose(term.wr_sel));
    cover property (@(posedge mem_clk) disable iff (rst) asyn && $rose(term.on));
    cover property (@(posedge clock) disable iff (rst) $rose(core_high_err));
endmodule

bind dtc_ctrl dtc_ctrl_chk u_chk (
    .clock(clock), .rst(rst), .nom_code(nom_code), .wr_code(wr_code), .cwl(cwl), .al(al),
    .sref_active(sref_active), .dll_off_ppd(dll_off_ppd), .dll_relock(dll_relock),
    .cfg_illegal(cfg_illegal), .core_high_err(core_high_err), .core_read_err(core_read_err),
    .mem_clk(mem_clk), .odt_pin(odt_pin), .wr_cmd(wr_cmd), .wr_chop(wr_chop),
    .rd_cmd(rd_cmd), .term(term)
);
`default_nettype wire

// file: dv/dtc_host_model.sv
// Purpose: memory controller model driving odt and command strobes
// Assumes: called from the bench; drives just after mem_clk rises
// Notes:   brk lets a scenario cut odt short on purpose
`timescale 1ns/10ps
`default_nettype none
module dtc_host_model (
    input  wire logic mem_clk,
    output var  logic odt_pin,
    output var  logic wr_cmd,
    output var  logic wr_chop,
    output var  logic rd_cmd
);
    initial begin
        {odt_pin, wr_cmd, wr_chop, rd_cmd} = 4'h0;
    end

    // cmd 1 write, 2 read, issued pre clocks after odt rises
    task automatic burst(input int pre, input int hold, input int cmd, input logic chop,
                         input logic brk);
        int n;
        n = hold;
        if (!brk && cmd == 1 && n < pre + (chop ? 4 : 6)) n = pre + (chop ? 4 : 6);
        if (!brk && n < 4) n = 4;
        @(posedge mem_clk);
        #1;
        odt_pin = 1'b1;
        for (int i = 0; i < n; i++) begin
            wr_cmd  = (i == pre) && (cmd == 1);
            rd_cmd  = (i == pre) && (cmd == 2);
            wr_chop = (i == pre) ? chop : !chop;
            @(posedge mem_clk);
            #1;
        end
        {odt_pin, wr_cmd, rd_cmd} = 3'h0;
        wr_chop = !wr_chop;
        repeat (16) @(posedge mem_clk);
    endtask
endmodule
`default_nettype wire

// file: hw/dtc_ctrl.sv
// Purpose: on-die termination control for data, strobe and mask balls
// Assumes: odt, write and read strobes are synchronous to mem_clk
// Notes:   config and state flags come from the core clock and are crossed
//
// Summary of operation
// [R1] odt ignored while in self refresh
// [R2] odt ignored when both terminations disabled
// [R3] async timing when dll off or relocking
// [R4] nominal field enables, odt switches on/off
// [R5] nominal codes six and seven are reserved
// [R6] controller keeps odt low during reads
// [R7] controller normally enables odt during writes
// [R8] nominal strength is 240 ohm over 2..12
// [R9] controller enables termination only when allowed
// [R10] no write termination: writes use nominal
// [R11] sync turn-on after cwl plus al minus 2
// [R12] sync turn-off after cwl plus al minus 2
// [R13] async on and off within 2 to 8.5 ns; code delays by ASYNC_MIN_CYC link clocks
// [R14] odt held high at least 4 clocks
// [R15] odt held 6 clocks after full write
// [R16] turn-off settles half a clock after latency
// [R17] write strength during burst, nominal afterwards
// [R18] dynamic active when any write-field bit set; code keeps it off for reserved code 3
// [R19] write field: off, div4, div2, reserved
// [R20] to write strength at wl minus 2
// [R21] back to nominal at off latency plus 4/6
// [R22] path chosen from dll and power-down state
`timescale 1ns/10ps
`default_nettype none
module dtc_ctrl (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic [2:0]        nom_code,
    input  wire logic [1:0]        wr_code,
    input  wire logic [3:0]        cwl,
    input  wire logic [3:0]        al,
    input  wire logic              sref_active,
    input  wire logic              dll_off_ppd,
    input  wire logic              dll_relock,
    output var  logic              cfg_busy,
    output var  logic              cfg_illegal,
    output var  logic              core_term_on,
    output var  logic              core_high_err,
    output var  logic              core_read_err,
    input  wire logic              mem_clk,
    input  wire logic              odt_pin,
    input  wire logic              wr_cmd,
    input  wire logic              wr_chop,
    input  wire logic              rd_cmd,
    output var  dtc_pkg::dtc_term_s term
);

    ////////////////////////////////////////////////////////////////////////
    // strength decode
    function automatic logic [3:0] nom_div(input logic [2:0] c);
        case (c)
            dtc_pkg::NOM_DIV4:  nom_div = 4'h4;
            dtc_pkg::NOM_DIV2:  nom_div = 4'h2;
            dtc_pkg::NOM_DIV6:  nom_div = 4'h6;
            dtc_pkg::NOM_DIV12: nom_div = 4'hC;
            dtc_pkg::NOM_DIV8:  nom_div = 4'h8;
            default:            nom_div = 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] wr_div(input logic [1:0] c);
        case (c)
            dtc_pkg::WR_DIV4: wr_div = 4'h4;
            dtc_pkg::WR_DIV2: wr_div = 4'h2;
            default:          wr_div = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] div_ohm(input logic [3:0] d);
        case (d)
            4'h2:    div_ohm = dtc_pkg::CAL_REF_OHM / 8'h02;
            4'h4:    div_ohm = dtc_pkg::CAL_REF_OHM / 8'h04;
            4'h6:    div_ohm = dtc_pkg::CAL_REF_OHM / 8'h06;
            4'h8:    div_ohm = dtc_pkg::CAL_REF_OHM / 8'h08;
            4'hC:    div_ohm = dtc_pkg::CAL_REF_OHM / 8'h0C;
            default: div_ohm = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // core side: configuration check and crossings
    dtc_pkg::dtc_cfg_s cfg_core;
    dtc_pkg::dtc_cfg_s cfg;
    logic              lrst;
    logic [2:0]        flags;
    logic              sref;
    logic              async_req;
    logic              dll_off;
    logic              relock;

    assign cfg_core.nom_code = nom_code;
    assign cfg_core.wr_code  = wr_code;
    assign cfg_core.cwl      = cwl;
    assign cfg_core.al       = al;

    // reserved codes flagged; the controller must not program them [R5]
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_illegal <= 1'b0;
        end else begin
            cfg_illegal <= (nom_code > dtc_pkg::NOM_DIV8) ||
                           (wr_code == dtc_pkg::WR_RSV);
        end
    end

    dtc_sync #(.W(1)) u_rst_sync (
        .clk  (mem_clk),
        .rst  (1'b0),
        .din  (rst),
        .dout (lrst)
    );

    dtc_xfer #(.W(13)) u_cfg_xfer (
        .src_clk  (clock),
        .src_rst  (rst),
        .src_data (cfg_core),
        .src_busy (cfg_busy),
        .dst_clk  (mem_clk),
        .dst_rst  (lrst),
        .dst_data (cfg)
    );

    dtc_sync #(.W(3)) u_flag_sync (
        .clk  (mem_clk),
        .rst  (lrst),
        .din  ({sref_active, dll_off_ppd, dll_relock}),
        .dout (flags)
    );

    assign sref    = flags[2];
    assign dll_off = flags[1];
    assign relock  = flags[0];
    assign async_req = dll_off | relock; // [R3] [R22]

    ////////////////////////////////////////////////////////////////////////
    // link side: registration of controller strobes
    logic odt_q;
    logic wr_q;
    logic chop_q;
    logic rd_q;
    logic odt_prev_ff;
    logic odt_gate;
    logic dyn_en;
    logic nom_en;

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            odt_q  <= 1'b0;
            wr_q   <= 1'b0;
            chop_q <= 1'b0;
            rd_q   <= 1'b0;
        end else begin
            odt_q  <= odt_pin;
            wr_q   <= wr_cmd;
            chop_q <= wr_chop;
            rd_q   <= rd_cmd;
        end
    end

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            odt_prev_ff <= 1'b0;
        end else begin
            odt_prev_ff <= odt_q;
        end
    end

    assign dyn_en = (cfg.wr_code[1] | cfg.wr_code[0]) &
                    (cfg.wr_code != dtc_pkg::WR_RSV); // [R18] [R19]
    assign nom_en = (cfg.nom_code != dtc_pkg::NOM_OFF); // [R4]
    // ignored in self refresh or with both fields off [R1] [R2]
    assign odt_gate = odt_q & ~sref & (nom_en | dyn_en);

    ////////////////////////////////////////////////////////////////////////
    // latencies
    logic [4:0] off_lat;
    logic [4:0] wr_lat;
    logic [4:0] hist_idx;

    assign wr_lat   = {1'b0, cfg.cwl} + {1'b0, cfg.al};
    assign off_lat  = wr_lat - dtc_pkg::LAT_OFFSET; // [R11] [R12]
    assign hist_idx = (off_lat < dtc_pkg::LAT_OFFSET) ? 5'h00 :
                      off_lat - dtc_pkg::LAT_OFFSET;

    ////////////////////////////////////////////////////////////////////////
    // synchronous path: delay line of the gated odt
    logic [dtc_pkg::HIST_DEPTH-1:0] hist_ff;

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= {hist_ff[dtc_pkg::HIST_DEPTH-2:0], odt_gate};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // asynchronous path: fixed short delay in link-clock terms
    localparam int ADLY = dtc_pkg::ASYNC_MIN_CYC;
    logic [ADLY-1:0] adly_ff;

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            adly_ff <= '0;
        end else begin
            adly_ff <= ADLY'({adly_ff, odt_gate}); // [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // termination on/off decision
    logic on_ff;
    logic nxt_on;

    always_comb begin
        if (async_req) begin
            nxt_on = adly_ff[ADLY-1]; // [R3] [R13] [R22]
        end else begin
            nxt_on = hist_ff[hist_idx]; // [R11] [R12]
        end
    end

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            on_ff <= 1'b0;
        end else begin
            on_ff <= nxt_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dynamic write strength window
    logic [5:0] wcnt_ff;
    logic       wact_ff;
    logic       wchop_ff;
    logic       wsel_ff;
    logic [5:0] wcnt_nx;
    logic [5:0] cnw_tgt;
    logic [5:0] cwn_tgt;

    assign wcnt_nx = wcnt_ff + 6'h01;
    assign cnw_tgt = {1'b0, wr_lat} - {1'b0, dtc_pkg::LAT_OFFSET}; // [R20]
    assign cwn_tgt = {1'b0, off_lat} +
                     (wchop_ff ? dtc_pkg::CHOP_EXTRA : dtc_pkg::FULL_EXTRA); // [R21]

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            wcnt_ff  <= 6'h00;
            wact_ff  <= 1'b0;
            wchop_ff <= 1'b0;
        end else if (wr_q) begin
            wcnt_ff  <= 6'h01;
            wact_ff  <= 1'b1;
            wchop_ff <= chop_q;
        end else if (wact_ff) begin
            wcnt_ff <= wcnt_nx;
            if (wcnt_nx == cwn_tgt) begin
                wact_ff <= 1'b0;
            end
        end
    end

    // switches with no mode register command [R17]
    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            wsel_ff <= 1'b0;
        end else if (!dyn_en || async_req) begin
            wsel_ff <= 1'b0;
        end else if (wact_ff && (wcnt_nx == cnw_tgt)) begin
            wsel_ff <= 1'b1; // [R20]
        end else if (wact_ff && (wcnt_nx == cwn_tgt)) begin
            wsel_ff <= 1'b0; // [R21]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strength select
    logic [3:0] div_sel;

    always_comb begin
        if (!on_ff) begin
            div_sel = 4'h0;
        end else if (wsel_ff) begin
            div_sel = wr_div(cfg.wr_code); // [R17] [R19]
        end else begin
            div_sel = nom_div(cfg.nom_code); // [R4] [R8] [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output stage half a clock after the latency edge
    always_ff @(negedge mem_clk) begin
        if (lrst) begin
            term <= '0;
        end else begin
            term.on     <= on_ff & (div_sel != 4'h0); // [R16]
            term.wr_sel <= on_ff & wsel_ff;
            term.div    <= div_sel;
            term.ohm    <= div_ohm(div_sel); // [R8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // controller protocol watch: high time and odt during reads or self refresh
    logic [4:0] hcnt_ff;
    logic [4:0] hreq_ff;
    logic       herr_ff;
    logic       rerr_ff;

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            hcnt_ff <= 5'h00;
            hreq_ff <= 5'h00;
        end else if (odt_q && (!odt_prev_ff || wr_q)) begin
            hcnt_ff <= 5'h01;
            hreq_ff <= (wr_q && !chop_q) ? dtc_pkg::LONG_MIN_HIGH
                                         : dtc_pkg::SHORT_MIN_HIGH; // [R14] [R15]
        end else if (odt_q && hcnt_ff != 5'h1F) begin
            hcnt_ff <= hcnt_ff + 5'h01;
        end
    end

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            herr_ff <= 1'b0;
        end else if (!odt_q && odt_prev_ff && (hcnt_ff < hreq_ff)) begin
            herr_ff <= 1'b1; // [R14] [R15]
        end
    end

    always_ff @(posedge mem_clk) begin
        if (lrst) begin
            rerr_ff <= 1'b0;
        end else if ((rd_q || sref) && odt_q) begin
            rerr_ff <= 1'b1; // [R6] [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status back to the core clock
    logic [2:0] stat_core;

    dtc_sync #(.W(3)) u_stat_sync (
        .clk  (clock),
        .rst  (rst),
        .din  ({on_ff, herr_ff, rerr_ff}),
        .dout (stat_core)
    );

    assign core_term_on  = stat_core[2];
    assign core_high_err = stat_core[1];
    assign core_read_err = stat_core[0];

endmodule
`default_nettype wire

// file: hw/dtc_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input is a level, stable for several destination clocks
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module dtc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);

    logic [W-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end

endmodule
`default_nettype wire

// file: hw/dtc_xfer.sv
// Purpose: toggle handshake carrying one word from the core to the link clock
// Assumes: source word may change at any time; latest value wins
// Notes:   held word is frozen while a transfer is in flight
`timescale 1ns/10ps
`default_nettype none
module dtc_xfer #(
    parameter int W = 8
) (
    input  wire logic         src_clk,
    input  wire logic         src_rst,
    input  wire logic [W-1:0] src_data,
    output var  logic         src_busy,
    input  wire logic         dst_clk,
    input  wire logic         dst_rst,
    output var  logic [W-1:0] dst_data
);

    logic [W-1:0] hold_ff;
    logic         req_ff;
    logic         ack_ff;
    logic         ack_sync;
    logic         req_sync;
    logic         req_seen_ff;

    assign src_busy = req_ff ^ ack_sync;

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            hold_ff <= '0;
            req_ff  <= 1'b0;
        end else if (!src_busy && (src_data != hold_ff)) begin
            hold_ff <= src_data;
            req_ff  <= ~req_ff;
        end
    end

    dtc_sync #(.W(1)) u_req_sync (
        .clk  (dst_clk),
        .rst  (dst_rst),
        .din  (req_ff),
        .dout (req_sync)
    );

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            req_seen_ff <= 1'b0;
            ack_ff      <= 1'b0;
            dst_data    <= '0;
        end else begin
            req_seen_ff <= req_sync;
            ack_ff      <= req_sync;
            if (req_sync != req_seen_ff) begin
                dst_data <= hold_ff;
            end
        end
    end

    dtc_sync #(.W(1)) u_ack_sync (
        .clk  (src_clk),
        .rst  (src_rst),
        .din  (ack_ff),
        .dout (ack_sync)
    );

endmodule
`default_nettype wire

// file: inc/dtc_pkg.sv
// Purpose: shared constants and carriers for the on-die termination control
// Assumes: latencies and async delays both counted in link clocks
// Notes:   mode register field codes kept as named constants
package dtc_pkg;

    localparam int CLK_PERIOD_PS   = 100000;
    localparam int ASYNC_MIN_PS    = 2000;
    localparam int ASYNC_MAX_PS    = 8500;
    localparam int ASYNC_MIN_RAW   = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_MAX_RAW   = ASYNC_MAX_PS / CLK_PERIOD_PS;
    localparam int ASYNC_MIN_CYC   = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
    localparam int ASYNC_MAX_CYC   = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;

    localparam logic [4:0] LAT_OFFSET     = 5'h02;
    localparam logic [4:0] SHORT_MIN_HIGH = 5'h04;
    localparam logic [4:0] LONG_MIN_HIGH  = 5'h06;
    localparam logic [5:0] CHOP_EXTRA     = 6'h04;
    localparam logic [5:0] FULL_EXTRA     = 6'h06;
    localparam int         HIST_DEPTH     = 32;

    localparam logic [2:0] NOM_OFF    = 3'h0;
    localparam logic [2:0] NOM_DIV4   = 3'h1;
    localparam logic [2:0] NOM_DIV2   = 3'h2;
    localparam logic [2:0] NOM_DIV6   = 3'h3;
    localparam logic [2:0] NOM_DIV12  = 3'h4;
    localparam logic [2:0] NOM_DIV8   = 3'h5;
    localparam logic [1:0] WR_OFF     = 2'h0;
    localparam logic [1:0] WR_DIV4    = 2'h1;
    localparam logic [1:0] WR_DIV2    = 2'h2;
    localparam logic [1:0] WR_RSV     = 2'h3;

    localparam logic [7:0] CAL_REF_OHM = 8'hF0;

    localparam logic [12:0] CFG_RESET = 13'h0000;

    typedef struct packed {
        logic [2:0] nom_code;
        logic [1:0] wr_code;
        logic [3:0] cwl;
        logic [3:0] al;
    } dtc_cfg_s;

    typedef struct packed {
        logic       on;
        logic       wr_sel;
        logic [3:0] div;
        logic [7:0] ohm;
    } dtc_term_s;

endpackage
